// >>> common/sbs_pkg.sv
`default_nettype none
package sbs_pkg;
    // Word layout: four byte lanes of data, then one parity bit per lane
    localparam int SBS_LANES = 4;
    localparam int SBS_LANE_W = 8;
    localparam int SBS_DATA_W = SBS_LANES * SBS_LANE_W;
    localparam int SBS_PAR_W = SBS_LANES;
    localparam int SBS_WORD_W = SBS_DATA_W + SBS_PAR_W;
    localparam int SBS_PAR_LSB = SBS_DATA_W;

    // Capacity variants, in 36-bit locations
    localparam int SBS_DEPTH_SMALL = 262144;
    localparam int SBS_DEPTH_LARGE = 524288;

    // Presence detect width; coding is arbitrary
    localparam int SBS_PD_W = 2;
    localparam logic [SBS_PD_W-1:0] SBS_PD_DEFAULT = 2'h0;

    // Values after reset
    localparam logic SBS_WR_PEND_RST = 1'h0;
    localparam logic [SBS_LANES-1:0] SBS_LANE_EN_RST = 4'h0;
    localparam logic [SBS_DATA_W-1:0] SBS_DATA_RST = 32'h0;
    localparam logic [SBS_PAR_W-1:0] SBS_PAR_RST = 4'h0;

    typedef enum logic [1:0] {
        SBS_ST_IDLE,
        SBS_ST_READ,
        SBS_ST_WRITE
    } sbs_state_t;
endpackage
`default_nettype wire

// >>> logic/sbs_sram_port.sv
`default_nettype none
module sbs_sram_port
    import sbs_pkg::*;
#(
    parameter int DEPTH = SBS_DEPTH_SMALL,
    parameter logic [SBS_PD_W-1:0] PD_CODE = SBS_PD_DEFAULT,
    localparam int ADDR_W = $clog2(DEPTH)
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic cycle_addr_strobe_n,
    input wire logic chip_sel_n,
    input wire logic [SBS_LANES-1:0] lane_write_n,
    input wire logic global_write_n,
    input wire logic out_enable_n,
    input wire logic [SBS_DATA_W-1:0] data_io_in,
    output logic [SBS_DATA_W-1:0] data_io_out,
    output logic data_io_oe,
    input wire logic [SBS_PAR_W-1:0] parity_io_in,
    output logic [SBS_PAR_W-1:0] parity_io_out,
    output logic parity_io_oe,
    output logic [SBS_PD_W-1:0] presence_detect
);

    // Only the two capacity variants are built
    if (DEPTH != SBS_DEPTH_SMALL && DEPTH != SBS_DEPTH_LARGE) begin : g_depth_check
        $error("sbs_sram_port: DEPTH must be 262144 or 524288");
    end

    // Lane slicing below assumes the lanes tile data and parity exactly
    if (SBS_DATA_W != SBS_LANES * SBS_LANE_W || SBS_PAR_W != SBS_LANES) begin : g_layout_check
        $error("sbs_sram_port: lane layout does not match the word");
    end

    // Storage, data and parity side by side in one word; never cleared
    logic [SBS_WORD_W-1:0] mem [DEPTH];

    // Cycle state
    sbs_state_t state_r;
    sbs_state_t state_nxt;
    logic [ADDR_W-1:0] addr_r;
    logic [ADDR_W-1:0] addr_nxt;

    // Write pipeline: launch flag and address
    logic wr_pend_r;
    logic wr_pend_nxt;
    logic [ADDR_W-1:0] wr_addr_r;
    logic [ADDR_W-1:0] wr_addr_nxt;

    // Write pipeline: captured word and lane mask
    logic [SBS_WORD_W-1:0] wr_word_r;
    logic [SBS_WORD_W-1:0] wr_word_nxt;
    logic [SBS_LANES-1:0] wr_lane_r;
    logic [SBS_LANES-1:0] wr_lane_nxt;

    // Read output registers
    logic [SBS_DATA_W-1:0] rd_data_r;
    logic [SBS_DATA_W-1:0] rd_data_nxt;
    logic [SBS_PAR_W-1:0] rd_par_r;
    logic [SBS_PAR_W-1:0] rd_par_nxt;

    // Presence code
    logic [SBS_PD_W-1:0] pd_r;
    logic [SBS_PD_W-1:0] pd_nxt;

    // Decode of the sampled controls
    logic strobe_now;
    logic sel_now;
    logic write_req;
    logic [SBS_LANES-1:0] lane_en;
    logic [ADDR_W-1:0] cyc_addr;

    // Cycle kind at this edge
    logic cyc_start;
    logic cyc_desel;
    logic cyc_cont;
    logic cyc_active;
    logic cyc_is_write;
    logic cyc_is_read;

    // Word assembly and read path
    logic [SBS_WORD_W-1:0] in_word;
    logic [SBS_WORD_W-1:0] mem_word;
    logic [SBS_WORD_W-1:0] rd_word;
    logic addr_match;
    logic drive_ok;

    // Truth table: strobe and select pick start, deselect or continue
    always_comb begin
        strobe_now = ~cycle_addr_strobe_n;
        sel_now = ~chip_sel_n;
        // Any low lane strobe or the global strobe makes a write
        write_req = ~global_write_n | ~(&lane_write_n);

        cyc_start = 1'h0;
        cyc_desel = 1'h0;
        cyc_cont = 1'h0;
        cyc_addr = addr_r;

        if (strobe_now) begin
            cyc_addr = addr_in;
            if (sel_now) begin
                cyc_start = 1'h1;
            end else begin
                cyc_desel = 1'h1;
            end
        end else begin
            // Select is not looked at while the strobe is high
            cyc_cont = (state_r != SBS_ST_IDLE);
        end

        // Type is taken afresh every edge, also in continued cycles
        cyc_active = cyc_start | cyc_cont;
        cyc_is_write = cyc_active & write_req;
        cyc_is_read = cyc_active & ~write_req;
    end

    // Cycle state and latched address
    always_comb begin
        state_nxt = state_r;
        addr_nxt = addr_r;
        if (strobe_now) begin
            addr_nxt = addr_in;
        end

        case (state_r)
            SBS_ST_IDLE: begin
                // A deselect while idle changes nothing
                if (cyc_is_write) begin
                    state_nxt = SBS_ST_WRITE;
                end else if (cyc_is_read) begin
                    state_nxt = SBS_ST_READ;
                end
            end
            SBS_ST_READ,
            SBS_ST_WRITE: begin
                if (cyc_desel) begin
                    state_nxt = SBS_ST_IDLE;
                end else if (cyc_is_write) begin
                    state_nxt = SBS_ST_WRITE;
                end else begin
                    state_nxt = SBS_ST_READ;
                end
            end
            default: begin
                state_nxt = SBS_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= SBS_ST_IDLE;
            addr_r <= '0;
        end else begin
            state_r <= state_nxt;
            addr_r <= addr_nxt;
        end
    end

    // Per-lane write enables, input word and read bypass
    for (genvar i = 0; i < SBS_LANES; i++) begin : g_lane
        localparam int LANE_LO = i * SBS_LANE_W;
        localparam int PAR_BIT = SBS_PAR_LSB + i;
        logic lane_hit;
        logic [SBS_LANE_W-1:0] lane_rd_data;
        logic lane_rd_par;

        // Inputs go straight into the launch word
        assign lane_en[i] = ~global_write_n | ~lane_write_n[i];
        assign in_word[LANE_LO +: SBS_LANE_W] = data_io_in[LANE_LO +: SBS_LANE_W];
        assign in_word[PAR_BIT] = parity_io_in[i];

        // Pending write not yet in the array must still be seen by a read
        always_comb begin
            lane_hit = wr_pend_r & wr_lane_r[i] & addr_match;
            if (lane_hit) begin
                lane_rd_data = wr_word_r[LANE_LO +: SBS_LANE_W];
                lane_rd_par = wr_word_r[PAR_BIT];
            end else begin
                lane_rd_data = mem_word[LANE_LO +: SBS_LANE_W];
                lane_rd_par = mem_word[PAR_BIT];
            end
        end

        assign rd_word[LANE_LO +: SBS_LANE_W] = lane_rd_data;
        assign rd_word[PAR_BIT] = lane_rd_par;
    end

    assign addr_match = (wr_addr_r == cyc_addr);
    assign mem_word = mem[cyc_addr];

    // Write launch: everything sampled now, array updated next edge
    always_comb begin
        wr_pend_nxt = cyc_is_write;
        wr_addr_nxt = wr_addr_r;
        wr_word_nxt = wr_word_r;
        // Mask drops back so a stale mask never commits twice
        wr_lane_nxt = SBS_LANE_EN_RST;

        if (cyc_is_write) begin
            wr_addr_nxt = cyc_addr;
            wr_word_nxt = in_word;
            wr_lane_nxt = lane_en;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_pend_r <= SBS_WR_PEND_RST;
            wr_addr_r <= '0;
        end else begin
            wr_pend_r <= wr_pend_nxt;
            wr_addr_r <= wr_addr_nxt;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_word_r <= '0;
            wr_lane_r <= SBS_LANE_EN_RST;
        end else begin
            wr_word_r <= wr_word_nxt;
            wr_lane_r <= wr_lane_nxt;
        end
    end

    // Self-timed commit; unwritten words read back as unknowns
    always_ff @(posedge ref_clk) begin
        for (int j = 0; j < SBS_LANES; j++) begin
            // Lane-wise writes of byte and parity bit leave the other lanes untouched
            if (wr_pend_r && wr_lane_r[j]) begin
                mem[wr_addr_r][j*SBS_LANE_W +: SBS_LANE_W] <= wr_word_r[j*SBS_LANE_W +: SBS_LANE_W];
                mem[wr_addr_r][SBS_PAR_LSB+j] <= wr_word_r[SBS_PAR_LSB+j];
            end
        end
    end

    // Flow-through read: word appears right after the edge that starts it
    // Data holds between reads; only a read edge loads it
    always_comb begin
        rd_data_nxt = rd_data_r;
        rd_par_nxt = rd_par_r;
        if (cyc_is_read) begin
            rd_data_nxt = rd_word[SBS_DATA_W-1:0];
            rd_par_nxt = rd_word[SBS_PAR_LSB +: SBS_PAR_W];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_r <= SBS_DATA_RST;
            rd_par_r <= SBS_PAR_RST;
        end else begin
            rd_data_r <= rd_data_nxt;
            rd_par_r <= rd_par_nxt;
        end
    end

    // PD_CODE after reset, SBS_PD_DEFAULT during it, held in a flop so the pins come from a register
    always_comb begin
        pd_nxt = PD_CODE;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pd_r <= SBS_PD_DEFAULT;
        end else begin
            pd_r <= pd_nxt;
        end
    end

    assign data_io_out = rd_data_r;
    assign parity_io_out = rd_par_r;
    assign presence_detect = pd_r;

    // Only a read state may turn the drivers on
    assign drive_ok = (state_r == SBS_ST_READ);

    // Enable is not clocked on purpose: the pin releases as soon as
    // output enable rises, which a registered enable could not do.
    // Gated by the read state so a write never turns the drivers on.
    assign data_io_oe = ~out_enable_n & drive_ok;
    assign parity_io_oe = ~out_enable_n & drive_ok;

endmodule
`default_nettype wire

// >>> verification/sbs_sram_port_props.sv
`default_nettype none
module sbs_sram_port_props
    import sbs_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic cycle_addr_strobe_n,
    input wire logic chip_sel_n,
    input wire logic [SBS_LANES-1:0] lane_write_n,
    input wire logic global_write_n,
    input wire logic out_enable_n,
    input wire logic [SBS_DATA_W-1:0] data_io_in,
    input wire logic [SBS_DATA_W-1:0] data_io_out,
    input wire logic data_io_oe,
    input wire logic [SBS_PAR_W-1:0] parity_io_in,
    input wire logic [SBS_PAR_W-1:0] parity_io_out,
    input wire logic parity_io_oe
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic wr;
    assign wr = ~&lane_write_n | ~global_write_n;
    sequence rd_go_s; !cycle_addr_strobe_n && !chip_sel_n && !wr; endsequence
    sequence wr_go_s; !cycle_addr_strobe_n && !chip_sel_n && wr; endsequence
    wr_no_drive_a: assert property (wr_go_s |=> !data_io_oe) else $error("write drove bus");
    wr_cont_a: assert property (cycle_addr_strobe_n && wr |=> !data_io_oe) else $error("continue write drove bus");
    desel_rel_a: assert property (!cycle_addr_strobe_n && chip_sel_n |=> !data_io_oe) else $error("deselect drove");
    oe_async_a: assert property (out_enable_n |-> !data_io_oe) else $error("drive without enable");
    rd_drive_a: assert property (rd_go_s ##1 !out_enable_n |-> data_io_oe) else $error("read not driven");
    par_pair_a: assert property (data_io_oe == parity_io_oe) else $error("parity enable differs");
    rd_hold_a: assert property (rd_go_s ##1 (cycle_addr_strobe_n && !wr) [*2] |->
        $stable(data_io_out) && $stable(parity_io_out)) else $error("continued read changed");
    wr_rd_a: assert property ((wr_go_s and !global_write_n) ##1 (cycle_addr_strobe_n && !wr) |=>
        data_io_out == $past(data_io_in, 2) && parity_io_out == $past(parity_io_in, 2))
        else $error("written word not returned");
endmodule
bind sbs_sram_port sbs_sram_port_props i_sbs_sram_port_props (.ref_clk(ref_clk), .rst_n(rst_n),
    .cycle_addr_strobe_n(cycle_addr_strobe_n), .chip_sel_n(chip_sel_n), .lane_write_n(lane_write_n),
    .global_write_n(global_write_n), .out_enable_n(out_enable_n), .data_io_in(data_io_in),
    .data_io_out(data_io_out), .data_io_oe(data_io_oe), .parity_io_in(parity_io_in),
    .parity_io_out(parity_io_out), .parity_io_oe(parity_io_oe));
`default_nettype wire

// >>> verification/sbs_ctrl_model.sv
`default_nettype none
module sbs_ctrl_model
    import sbs_pkg::*;
(
    input wire logic ref_clk,
    input wire logic drv,
    input wire logic [SBS_WORD_W-1:0] wdata,
    input wire logic dev_oe,
    input wire logic [SBS_WORD_W-1:0] dev_q,
    output logic [SBS_WORD_W-1:0] bus
);
    logic [SBS_WORD_W-1:0] last_r;
    always_ff @(posedge ref_clk) last_r <= bus;
    // Released bus flips so stale data never passes
    always_comb begin
        if (drv) bus = wdata;
        else if (dev_oe) bus = dev_q;
        else bus = ~last_r;
    end
endmodule
`default_nettype wire

// >>> verification/tb_sbs_sram_port.sv
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_total++; $display("unexpected %0t %h %h", $time, a, b); end end
module tb_sbs_sram_port
    import sbs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'h0, rst_n = 1'h0, strb = 1'h1, cs = 1'h1, gw = 1'h1, oen = 1'h1, c_drv = 1'h0;
    logic [3:0] lw = 4'hf;
    logic [17:0] addr = 18'h0;
    logic [35:0] c_w = 36'h0, exp_w, bus;
    wire [31:0] dq;
    wire [3:0] dp;
    wire doe, poe;
    int err_total = 0, n_tests = 0, cyc_cnt = 0;
    sbs_sram_port #(.DEPTH(SBS_DEPTH_SMALL)) i_sbs_sram_port (.ref_clk(ref_clk), .rst_n(rst_n), .addr_in(addr),
        .cycle_addr_strobe_n(strb), .chip_sel_n(cs), .lane_write_n(lw), .global_write_n(gw), .out_enable_n(oen),
        .data_io_in(bus[31:0]), .data_io_out(dq), .data_io_oe(doe), .parity_io_in(bus[35:32]),
        .parity_io_out(dp), .parity_io_oe(poe), .presence_detect());
    sbs_ctrl_model i_sbs_ctrl_model (.ref_clk(ref_clk), .drv(c_drv), .wdata(c_w), .dev_oe(doe),
        .dev_q({dp, dq}), .bus(bus));
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    task give_verdict;
        $display("tests %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc_cnt++;
        if (cyc_cnt > 3000) begin
            err_total++;
            give_verdict;
        end
    end
    task cyc(input logic s, c, g, input logic [3:0] l, input logic [17:0] a, input logic [35:0] w);
        @(posedge ref_clk);
        strb <= s;
        cs <= c;
        gw <= g;
        lw <= l;
        addr <= a;
        c_w <= w;
        c_drv <= ~g | ~&l;
        oen <= 1'h1;
    endtask
    task rd(input logic [17:0] a, input logic [35:0] e);
        cyc(1'h0, 1'h0, 1'h1, 4'hf, a, 36'h0);
        @(posedge ref_clk);
        oen <= 1'h0;
        #1;
        `CHK({dp, dq}, e)
        `CHK({doe, poe}, 2'h3)
    endtask
    task t_reset;
        @(posedge ref_clk);
        oen <= 1'h0;
        #1;
        `CHK({doe, poe}, 2'h0)
    endtask
    task t_lanes;
        exp_w = 36'h0_1234_5678;
        cyc(1'h0, 1'h0, 1'h0, 4'ha, 18'h3ffff, exp_w);
        rd(18'h3ffff, exp_w);
        for (int i = 0; i < 4; i++) begin
            cyc(1'h0, 1'h0, 1'h1, ~(4'h1 << i), 18'h3ffff, 36'hf_ffff_ffff);
            exp_w[8*i +: 8] = 8'hff;
            exp_w[32+i] = 1'h1;
            rd(18'h3ffff, exp_w);
        end
    endtask
    task t_cont;
        cyc(1'h0, 1'h0, 1'h0, 4'hf, 18'h6, 36'h6_0000_0066);
        cyc(1'h0, 1'h0, 1'h1, 4'hf, 18'h5, 36'h0);
        cyc(1'h1, 1'h1, 1'h0, 4'hf, 18'h6, 36'h9_aaaa_5555);
        rd(18'h5, 36'h9_aaaa_5555);
        rd(18'h6, 36'h6_0000_0066);
    endtask
    task t_hold;
        cyc(1'h0, 1'h0, 1'h0, 4'hf, 18'h9, 36'h5_a5a5_3c3c);
        cyc(1'h1, 1'h1, 1'h1, 4'hf, 18'h0, 36'h0);
        cyc(1'h1, 1'h1, 1'h1, 4'hf, 18'h0, 36'h0);
        cyc(1'h0, 1'h0, 1'h1, 4'hf, 18'h9, 36'h0);
        cyc(1'h1, 1'h1, 1'h1, 4'hf, 18'h0, 36'h0);
        cyc(1'h1, 1'h1, 1'h1, 4'hf, 18'h0, 36'h0);
        @(posedge ref_clk);
        oen <= 1'h0;
        #1;
        `CHK({dp, dq}, 36'h5_a5a5_3c3c)
        `CHK({doe, poe}, 2'h3)
    endtask
    task t_release;
        @(posedge ref_clk);
        oen <= 1'h1;
        #1;
        `CHK(doe, 1'h0)
        cyc(1'h0, 1'h1, 1'h1, 4'hf, 18'h5, 36'h0);
        @(posedge ref_clk);
        oen <= 1'h0;
        #1;
        `CHK({doe, poe}, 2'h0)
        cyc(1'h0, 1'h0, 1'h1, 4'h0, 18'h7, 36'h1_0000_0001);
        @(posedge ref_clk);
        oen <= 1'h0;
        #1;
        `CHK({doe, poe}, 2'h0)
    endtask
    initial begin
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'h1;
        t_reset;
        t_lanes;
        t_cont;
        t_hold;
        t_release;
        give_verdict;
    end
endmodule
`default_nettype wire
